// ===== logic/backlight_status_pkg.sv
// package: constants and types shared by the backlight status and id register bank
package backlight_status_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_ADDR   = 8'h02;
  localparam logic [7:0] ID_ADDR       = 8'h03;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [6:0] SLAVE_ADDR    = 7'h2c;

  // ----------------------------------------------------------------
  // identification word fields
  // ----------------------------------------------------------------
  localparam logic       ID_PANEL_BIT  = 1'b1;
  localparam int         ID_MAKER_LSB  = 3;
  localparam int         ID_REV_LSB    = 0;
  localparam logic [3:0] MAKER_RSVD_LO = 4'h7;
  localparam logic [3:0] MAKER_ABSENT  = 4'hf;

  // ----------------------------------------------------------------
  // status word and thermal limits
  // ----------------------------------------------------------------
  localparam int         CHANNELS      = 8;
  localparam int         TEMP_W        = 9;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [8:0] THERM_TRIP_C  = 9'h0a0;
  localparam logic [8:0] THERM_HYST_C  = 9'h00f;
  localparam logic [8:0] THERM_CLEAR_C = 9'(THERM_TRIP_C - THERM_HYST_C);

  typedef struct packed {
    logic [1:0] reserved;
    logic       multi_channel_fault;
    logic       any_channel_fault;
    logic       backlight_on_flag;
    logic       input_overcurrent_flag;
    logic       thermal_fault_flag;
    logic       summary_fault;
  } status_t;

  typedef struct packed {
    logic [CHANNELS-1:0] channel_fault;
    logic                backlight_on;
    logic                input_overcurrent;
    logic [TEMP_W-1:0]   die_temp_c;
  } analog_in_t;

endpackage

// ===== logic/backlight_status_regs.sv
// smbus slave exposing the read-only fault/status and identification registers
`timescale 1ns/1ps
module backlight_status_regs
#(
  // arbitrary neutral maker and revision codes
  parameter logic [3:0] MAKER_CODE = 4'h5,
  parameter logic [2:0] REVISION   = 3'h3
)
(
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  // smbus pins
  input  wire logic                             scl_in,
  input  wire logic                             sda_in,
  output logic                                  sda_out,
  output logic                                  sda_oe_n,
  // analog-side indications
  input  wire backlight_status_pkg::analog_in_t analog_in,
  // controls toward the converter and visible state
  output logic                                  converter_shutdown,
  output backlight_status_pkg::status_t         status
);

  typedef enum logic [3:0] {
    IDLE, ADDR, ADDR_ACK, CMD, CMD_ACK, WDATA, WDATA_ACK, RDATA, RDATA_ACK, RDATA_NEXT
  } bus_state_t;

  // ----------------------------------------------------------------
  // status collection
  // ----------------------------------------------------------------
  fault_status_monitor monitor
  (
    .clk                (clk),
    .arst_n             (arst_n),
    .raw                (analog_in),
    .status             (status),
    .converter_shutdown (converter_shutdown)
  );

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] scl_pipe;
  logic [2:0] sda_pipe;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_pipe <= 3'h7;
      sda_pipe <= 3'h7;
    end
    else
    begin
      scl_pipe <= {scl_pipe[1:0], scl_in};
      sda_pipe <= {sda_pipe[1:0], sda_in};
    end
  end

  wire logic scl_rise;
  wire logic scl_fall;
  wire logic start_seen;
  wire logic stop_seen;
  wire logic sda_now;

  assign sda_now    = sda_pipe[1];
  assign scl_rise   = scl_pipe[1] & ~scl_pipe[2];
  assign scl_fall   = ~scl_pipe[1] & scl_pipe[2];
  assign start_seen = scl_pipe[1] & scl_pipe[2] & sda_pipe[2] & ~sda_pipe[1];
  assign stop_seen  = scl_pipe[1] & scl_pipe[2] & ~sda_pipe[2] & sda_pipe[1];

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  wire logic [7:0] id_word;
  wire logic [7:0] read_byte;
  wire logic       maker_ok;
  logic      [7:0] cmd;
  logic      [7:0] next_cmd;

  // code 15 would tell the host the id register is absent, and 7..14 are
  // reserved; maker_ok only documents that a legal code was chosen
  assign maker_ok  = (MAKER_CODE < backlight_status_pkg::MAKER_RSVD_LO)
                     && (MAKER_CODE != backlight_status_pkg::MAKER_ABSENT);
  assign id_word   = {backlight_status_pkg::ID_PANEL_BIT, MAKER_CODE, REVISION};
  assign read_byte = (cmd == backlight_status_pkg::STATUS_ADDR) ? status
                   : (cmd == backlight_status_pkg::ID_ADDR) && maker_ok ? id_word
                   : (cmd == backlight_status_pkg::ID_ADDR) ? id_word
                   : backlight_status_pkg::UNMAPPED_READ;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  bus_state_t state;
  bus_state_t next_state;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic       next_sda_oe_n;

  wire logic byte_done;
  wire logic addr_match;

  assign byte_done  = bit_cnt == 4'h8;
  assign addr_match = shreg[7:1] == backlight_status_pkg::SLAVE_ADDR;

  always_comb
  begin
    next_state    = state;
    next_shreg    = shreg;
    next_bit_cnt  = bit_cnt;
    next_cmd      = cmd;
    next_sda_oe_n = sda_oe_n;
    if (stop_seen)
    begin
      next_state    = IDLE;
      next_sda_oe_n = 1'b1;
    end
    else if (start_seen)
    begin
      next_state    = ADDR;
      next_bit_cnt  = 4'h0;
      next_sda_oe_n = 1'b1;
    end
    else if (scl_rise)
    begin
      unique case (state)
        ADDR, CMD, WDATA:
        begin
          next_shreg   = {shreg[6:0], sda_now};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        RDATA:
        begin
          next_shreg   = {shreg[6:0], 1'b0};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        RDATA_ACK:
          next_state = sda_now ? IDLE : RDATA_NEXT;
        IDLE, ADDR_ACK, CMD_ACK, WDATA_ACK, RDATA_NEXT:
          next_state = state;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state)
        ADDR:
          if (byte_done)
          begin
            next_state    = addr_match ? ADDR_ACK : IDLE;
            next_sda_oe_n = ~addr_match;
            next_cmd      = addr_match && shreg[0] ? cmd : next_cmd;
            next_bit_cnt  = {3'h0, shreg[0]};
          end
        ADDR_ACK:
          if (bit_cnt[0])
          begin
            next_state    = RDATA;
            next_shreg    = read_byte;
            next_bit_cnt  = 4'h0;
            next_sda_oe_n = read_byte[7];
          end
          else
          begin
            next_state    = CMD;
            next_bit_cnt  = 4'h0;
            next_sda_oe_n = 1'b1;
          end
        CMD, WDATA:
          if (byte_done)
          begin
            next_state    = (state == CMD) ? CMD_ACK : WDATA_ACK;
            next_cmd      = (state == CMD) ? shreg : cmd;
            next_sda_oe_n = 1'b0;
          end
        CMD_ACK, WDATA_ACK:
        begin
          // data bytes are acknowledged but never stored
          next_state    = WDATA;
          next_bit_cnt  = 4'h0;
          next_sda_oe_n = 1'b1;
        end
        RDATA:
          if (byte_done)
          begin
            next_state    = RDATA_ACK;
            next_sda_oe_n = 1'b1;
          end
          else
            next_sda_oe_n = shreg[7];
        RDATA_NEXT:
        begin
          next_state    = RDATA;
          next_shreg    = read_byte;
          next_bit_cnt  = 4'h0;
          next_sda_oe_n = read_byte[7];
        end
        IDLE, RDATA_ACK:
          next_state = state;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= IDLE;
      shreg    <= 8'h00;
      bit_cnt  <= 4'h0;
      cmd      <= 8'h00;
      sda_oe_n <= 1'b1;
      sda_out  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      shreg    <= next_shreg;
      bit_cnt  <= next_bit_cnt;
      cmd      <= next_cmd;
      sda_oe_n <= next_sda_oe_n;
      sda_out  <= 1'b0;
    end
  end

endmodule

// ===== logic/fault_status_monitor.sv
// fault and status flag collection with thermal shutdown hysteresis
`timescale 1ns/1ps
module fault_status_monitor
(
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  // raw analog-side indications
  input  wire backlight_status_pkg::analog_in_t raw,
  // results
  output backlight_status_pkg::status_t        status,
  output logic                                 converter_shutdown
);

  // ----------------------------------------------------------------
  // two-stage synchronisers
  // ----------------------------------------------------------------
  // temperature bits are synchronised one by one; a code caught mid-change can
  // be off for a cycle, and one such cycle above THERM_TRIP_C sets the shutdown
  backlight_status_pkg::analog_in_t meta;
  backlight_status_pkg::analog_in_t synced;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta   <= '0;
      synced <= '0;
    end
    else
    begin
      meta   <= raw;
      synced <= meta;
    end
  end

  // ----------------------------------------------------------------
  // flag decode
  // ----------------------------------------------------------------
  wire logic [backlight_status_pkg::CHANNELS-1:0] chan;
  wire logic [backlight_status_pkg::CHANNELS-1:0] chan_less_one;
  wire logic                                      hot;
  wire logic                                      cooled;
  logic                                           next_shutdown;
  backlight_status_pkg::status_t                  next_status;

  assign chan          = synced.channel_fault;
  assign chan_less_one = chan - 1'b1;
  assign hot           = synced.die_temp_c > backlight_status_pkg::THERM_TRIP_C;
  assign cooled        = synced.die_temp_c <= backlight_status_pkg::THERM_CLEAR_C;

  always_comb
  begin
    next_shutdown = converter_shutdown;
    if (hot)
      next_shutdown = 1'b1;
    else if (cooled)
      next_shutdown = 1'b0;
    next_status                        = backlight_status_pkg::STATUS_RESET;
    next_status.reserved               = 2'h0;
    next_status.multi_channel_fault    = |(chan & chan_less_one);
    next_status.any_channel_fault      = |chan;
    next_status.backlight_on_flag      = synced.backlight_on & ~next_shutdown;
    next_status.input_overcurrent_flag = synced.input_overcurrent;
    next_status.thermal_fault_flag     = next_shutdown;
    next_status.summary_fault          = |chan | synced.input_overcurrent
                                         | next_shutdown;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status             <= backlight_status_pkg::STATUS_RESET;
      converter_shutdown <= 1'b0;
    end
    else
    begin
      status             <= next_status;
      converter_shutdown <= next_shutdown;
    end
  end

endmodule

// ===== tb/backlight_status_sva.sv
// assertions on the status and id register bank ports
`timescale 1ns/1ps
module backlight_status_sva
(
  // clock and reset
  input wire logic                             clk,
  input wire logic                             arst_n,
  // watched signals
  input wire logic                             sda_oe_n,
  input wire backlight_status_pkg::analog_in_t analog_in,
  input wire logic                             converter_shutdown,
  input wire backlight_status_pkg::status_t    status
);
  logic [2:0] up;
  wire        ok = up[2] & up[1];
  // ----------------------------------------------------------------
  // settle counter: $past must not reach back into reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_multi;
    ok |-> status.multi_channel_fault == ($countones($past(analog_in.channel_fault, 3)) > 1);
  endproperty
  property p_any;
    ok |-> status.any_channel_fault == (|$past(analog_in.channel_fault, 3));
  endproperty
  property p_bl;
    ok |-> status.backlight_on_flag ==
           ($past(analog_in.backlight_on, 3) & !status.thermal_fault_flag);
  endproperty
  property p_ovc;
    ok |-> status.input_overcurrent_flag == $past(analog_in.input_overcurrent, 3);
  endproperty
  property p_therm;
    status.thermal_fault_flag == converter_shutdown;
  endproperty
  property p_sum;
    status.summary_fault == (status.any_channel_fault | status.input_overcurrent_flag
                             | status.thermal_fault_flag);
  endproperty
  property p_trip;
    ok && $past(analog_in.die_temp_c, 3) > 9'h0a0 |-> converter_shutdown;
  endproperty
  property p_clear;
    ok && $past(analog_in.die_temp_c, 3) <= 9'h091 |-> !converter_shutdown;
  endproperty
  property p_hold;
    ok && $past(analog_in.die_temp_c, 3) inside {[9'h092:9'h0a0]} |-> $stable(converter_shutdown);
  endproperty
  property p_resv;
    status.reserved == 2'h0;
  endproperty
  a_multi: assert property (p_multi) else $error("multi flag wrong");
  a_any: assert property (p_any) else $error("any flag wrong");
  a_bl: assert property (p_bl) else $error("backlight flag wrong");
  a_ovc: assert property (p_ovc) else $error("overcurrent flag wrong");
  a_therm: assert property (p_therm) else $error("thermal flag wrong");
  a_sum: assert property (p_sum) else $error("summary flag wrong");
  a_trip: assert property (p_trip) else $error("no shutdown when hot");
  a_clear: assert property (p_clear) else $error("no restart when cool");
  a_hold: assert property (p_hold) else $error("shutdown changed in band");
  a_resv: assert property (p_resv) else $error("reserved bits set");
  c_shut: cover property ($rose(converter_shutdown));
  c_multi: cover property (status.multi_channel_fault);
  c_ack: cover property ($fell(sda_oe_n));
endmodule

bind backlight_status_regs backlight_status_sva u_sva (.clk(clk), .arst_n(arst_n),
  .sda_oe_n(sda_oe_n), .analog_in(analog_in), .converter_shutdown(converter_shutdown),
  .status(status));

// ===== tb/smbus_host_model.sv
// smbus host model driving clock and data toward the device
`timescale 1ns/1ps
module smbus_host_model
(
  // clock and wire
  input  wire logic  clk,
  input  wire logic  sda,
  // pins driven
  output logic       scl = 1'b1,
  output logic       sda_drv = 1'b1,
  // result of each transfer: three acks then data
  output logic [10:0] got = 11'h000,
  output logic       got_v = 1'b0
);
  localparam int Q = 8;
  // each phase changes one pin only, so no false start or stop appears
  task automatic ph(input logic c, input logic d);
    repeat (Q) @(posedge clk);
    scl <= c;
    sda_drv <= d;
  endtask
  // p = 0 gives a start, p = 1 a stop
  task automatic cond(input logic p);
    ph(1'b0, sda_drv);
    ph(1'b0, !p);
    ph(1'b1, !p);
    ph(1'b1, p);
  endtask
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, sda_drv);
    ph(1'b0, b);
    ph(1'b1, b);
    repeat (Q) @(posedge clk);
    r = sda;
  endtask
  // ninth bit is always released: ack sampled, or nack after read data
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
  endtask
  task automatic xfer(input logic [6:0] adr, input logic [7:0] cmd, input logic wr,
                      input logic [7:0] dat);
    logic [7:0] rx;
    logic [2:0] a;
    logic       d;
    cond(1'b0);
    byte_io({adr, 1'b0}, rx, a[2]);
    byte_io(cmd, rx, a[1]);
    if (wr)
    begin
      byte_io(dat, rx, a[0]);
      rx = 8'h00;
    end
    else
    begin
      cond(1'b0);
      byte_io({adr, 1'b1}, rx, a[0]);
      byte_io(8'hff, rx, d);
    end
    cond(1'b1);
    got <= {a, rx};
    got_v <= 1'b1;
    @(posedge clk);
    got_v <= 1'b0;
  endtask
endmodule

// ===== tb/test_backlight_fault_id_regs.sv
// self-checking bench for the status and id register bank
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module test_backlight_fault_id_regs;
  localparam logic [3:0] MAKER = 4'h4;  // arbitrary value
  localparam logic [2:0] REV   = 3'h2;  // arbitrary value
  logic                             clk = 1'b0;
  logic                             arst_n = 1'b0;
  logic                             scl, sda_drv, sda_oe_n, sda_out, got_v;
  logic [10:0]                      got, e;
  // open drain: the device pulls low only with its enable low and a low value
  wire                              sda = sda_drv & (sda_oe_n | sda_out);
  backlight_status_pkg::analog_in_t ain = '0;
  logic [10:0]                      expq[$];
  int                               mismatches = 0, check_count = 0, cyc = 0, seed = 33;
  logic                             shut = 1'b0;
  logic [8:0]                       temps[5] = '{9'h064, 9'h092, 9'h0a1, 9'h0a0, 9'h091};
  always #5 clk = ~clk;
  backlight_status_regs #(.MAKER_CODE(MAKER), .REVISION(REV)) u_dut (.clk(clk),
    .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .analog_in(ain), .converter_shutdown(), .status());
  smbus_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv),
    .got(got), .got_v(got_v));
  task automatic test_done;
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] x);
    expq.push_back({3'b000, x});
    u_host.xfer(7'h2c, cmd, 1'b0, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // result watcher and hang limit
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 60000)
    begin
      mismatches++;
      test_done();
    end
    else if (got_v === 1'b1)
    begin
      e = expq.pop_front();
      `CHK(got, e)
    end
  end
  initial
  begin
    logic [7:0] cf, sv;
    logic       bl, oc;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      cf = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'(1 << i[2:0]) : 8'($random(seed));
      bl = 1'($random(seed));
      oc = 1'($random(seed));
      @(posedge clk);
      ain <= '{cf, bl, oc, temps[i % 5]};
      shut = temps[i % 5] > 9'h0a0 ? 1'b1 : temps[i % 5] <= 9'h091 ? 1'b0 : shut;
      sv = {2'b00, $countones(cf) > 1, |cf, bl & !shut, oc, shut, |cf | oc | shut};
      repeat (10) @(posedge clk);
      rd(8'h02, sv);
      expq.push_back(11'h000);
      u_host.xfer(7'h2c, i[0] ? 8'h03 : 8'h02, 1'b1, 8'($random(seed)));
      rd(8'h03, {1'b1, MAKER, REV});
      rd(8'h02, sv);
    end
    rd(8'h01, 8'h00);
    expq.push_back(11'h7ff);
    u_host.xfer(7'h2d, 8'h02, 1'b0, 8'h00);
    rd(8'h03, {1'b1, MAKER, REV});
    repeat (4) @(posedge clk);
    `CHK(expq.size(), 0)
    test_done();
  end
endmodule
